// >>> src/ofcrc_pkg.sv
// Package with register map, field layout and timing constants for the clock fault block
package ofcrc_pkg;
  localparam int unsigned REG_W          = 16;
  localparam int unsigned ADDR_W         = 4;
  // Byte offsets on the register bus
  localparam logic [ADDR_W-1:0] FAULT_OFFS   = 4'h0;
  localparam logic [ADDR_W-1:0] REQEN_OFFS   = 4'h4;
  localparam logic [ADDR_W-1:0] STATUS_OFFS  = 4'h8;
  // Fault register fields
  localparam int unsigned OSC_ONE_FLAG_BIT  = 0;
  localparam int unsigned OSC_TWO_FLAG_BIT  = 1;
  localparam int unsigned OSC_ONE_CNTEN_BIT = 6;
  localparam int unsigned OSC_TWO_CNTEN_BIT = 7;
  localparam logic [REG_W-1:0] FAULT_RW_MASK = 16'h00c3;
  localparam logic [REG_W-1:0] FAULT_RESET   = 16'h00c1;
  // Request enable register fields: aux, main, sub-main, module clock
  localparam int unsigned NUM_CLK        = 4;
  localparam logic [REG_W-1:0] REQEN_RW_MASK = 16'h000f;
  localparam logic [REG_W-1:0] REQEN_RESET   = 16'h0007;
  // Status register fields
  localparam int unsigned STAT_COMB_BIT  = 0;
  localparam int unsigned STAT_COND1_BIT = 1;
  localparam int unsigned STAT_COND2_BIT = 2;
  localparam int unsigned STAT_CLK_LSB   = 4;
  // Startup fault counter: stable run of oscillator cycles
  localparam int unsigned START_RUN_CYCLES = 1024;
  localparam int unsigned START_CNT_W      = 11;
endpackage

// >>> src/ofcrc_start_counter.sv
// Startup fault counter for one oscillator
`timescale 1ns/100ps
module ofcrc_start_counter
  import ofcrc_pkg::*;
#(
  parameter int unsigned RUN_CYCLES = START_RUN_CYCLES
)
(
  input  wire logic ref_clk_i,
  input  wire logic rst_b_i,
  input  wire logic enable_i,
  input  wire logic osc_tick_i,
  input  wire logic osc_lost_i,
  output logic      fault_o
);
  localparam logic [START_CNT_W-1:0] RUN_LAST = START_CNT_W'(RUN_CYCLES);

  logic [START_CNT_W-1:0] count_q;
  logic [START_CNT_W-1:0] count_d;

  always_comb
  begin
    count_d = count_q;
    if (!enable_i || osc_lost_i)
    begin
      count_d = '0;
    end
    // Count ticks up to stable run
    else if (osc_tick_i && count_q != RUN_LAST)
    begin
      count_d = count_q + START_CNT_W'(1);
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
    begin
      count_q <= '0;
    end
    else
    begin
      count_q <= count_d;
    end
  end

  assign fault_o = enable_i && (count_q != RUN_LAST);

  a_cnt_disabled_zero: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    !enable_i |=> count_q == '0) else $error("counter not cleared when disabled");
endmodule

// >>> src/ofcrc_req_gate.sv
// Gating of conditional clock requests by their enable bits
`timescale 1ns/100ps
module ofcrc_req_gate
  import ofcrc_pkg::*;
#(
  parameter int unsigned N = NUM_CLK
)
(
  input  wire logic         ref_clk_i,
  input  wire logic         rst_b_i,
  input  wire logic [N-1:0] enable_i,
  input  wire logic [N-1:0] request_i,
  output logic      [N-1:0] request_o
);
  logic [N-1:0] req_q;
  logic [N-1:0] req_d;

  genvar g;
  generate
    for (g = 0; g < N; g++)
    begin : gate
      assign req_d[g] = request_i[g] & enable_i[g];
    end
  endgenerate

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
    begin
      req_q <= '0;
    end
    else
    begin
      req_q <= req_d;
    end
  end

  assign request_o = req_q;

  a_req_gated: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (request_o & ~$past(enable_i)) == '0) else $error("request passed while disabled");
endmodule

// >>> src/ofcrc_top.sv
// Oscillator fault flags and clock request enables behind a Wishbone slave
//
// Overview of operation
// - Unused bits of both registers read zero and ignore writes.
// - Fault bit 7 enables second oscillator startup counter, resets to one.
// - Fault bit 6 enables first oscillator startup counter, resets to one.
// - Cleared counter enable stops its counter and holds count at zero.
// - Fault bit 1 resets zero, set while second oscillator faults.
// - Either oscillator fault flag set also sets combined interrupt flag.
// - Software clears second flag by writing zero; persistent fault sets again.
// - Without second oscillator its flag is read-only zero.
// - Fault bit 0 resets to one, set on first oscillator fault.
// - Software clears first flag; persistent fault sets it again at once.
// - Fault flags are sticky until software clears them.
// - Request bit 3 resets zero, enables module clock requests.
// - Request bit 2 resets one, enables sub-main clock requests.
// - Request bit 1 resets one, enables main clock requests.
// - Request bit 0 resets one, enables auxiliary clock requests.
// - Cleared request enable makes that clock ignore module requests.
`timescale 1ns/100ps
module ofcrc_top
  import ofcrc_pkg::*;
#(
  parameter bit          HAS_OSC_TWO = 1'b1,
  parameter int unsigned RUN_CYCLES  = START_RUN_CYCLES
)
(
  input  wire logic               ref_clk_i,
  input  wire logic               rst_b_i,
  // Wishbone classic slave
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire logic [ADDR_W-1:0]  wb_adr_i,
  input  wire logic [3:0]         wb_sel_i,
  input  wire logic [31:0]        wb_dat_i,
  output logic      [31:0]        wb_dat_o,
  output logic                    wb_ack_o,
  output logic                    wb_err_o,
  // Oscillator fault sources
  input  wire logic               osc_one_tick_i,
  input  wire logic               osc_one_lost_i,
  input  wire logic               osc_two_tick_i,
  input  wire logic               osc_two_lost_i,
  // Conditional module requests, bit order aux, main, sub-main, module
  input  wire logic [NUM_CLK-1:0] clk_request_i,
  output logic      [NUM_CLK-1:0] clk_request_o,
  output logic                    combined_osc_fault_irq_flag_o
);
  logic               osc_one_start_counter_enable_q;
  logic               osc_one_start_counter_enable_d;
  logic               osc_two_start_counter_enable_q;
  logic               osc_two_start_counter_enable_d;
  logic               osc_one_fault_flag_q;
  logic               osc_one_fault_flag_d;
  logic               osc_two_fault_flag_q;
  logic               osc_two_fault_flag_d;
  logic [NUM_CLK-1:0] req_en_q;
  logic [NUM_CLK-1:0] req_en_d;
  logic               comb_flag_q;
  logic               comb_flag_d;
  logic               ack_q;
  logic               ack_d;
  logic               err_q;
  logic               err_d;
  logic [31:0]        rdata_q;
  logic [31:0]        rdata_d;
  logic               cnt_one_fault;
  logic               cnt_two_fault;
  logic               cond_one;
  logic               cond_two;
  logic               req_phase;
  logic               wr_fault;
  logic               wr_reqen;
  logic               wr_low_byte;
  logic [REG_W-1:0]   fault_view;
  logic [REG_W-1:0]   reqen_view;
  logic [REG_W-1:0]   status_view;

  function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] o);
    return a == o;
  endfunction

  ofcrc_start_counter #(
    .RUN_CYCLES (RUN_CYCLES)
  ) u_cnt_one (
    .ref_clk_i  (ref_clk_i),
    .rst_b_i    (rst_b_i),
    .enable_i   (osc_one_start_counter_enable_q),
    .osc_tick_i (osc_one_tick_i),
    .osc_lost_i (osc_one_lost_i),
    .fault_o    (cnt_one_fault)
  );

  ofcrc_start_counter #(
    .RUN_CYCLES (RUN_CYCLES)
  ) u_cnt_two (
    .ref_clk_i  (ref_clk_i),
    .rst_b_i    (rst_b_i),
    .enable_i   (osc_two_start_counter_enable_q),
    .osc_tick_i (osc_two_tick_i),
    .osc_lost_i (osc_two_lost_i),
    .fault_o    (cnt_two_fault)
  );

  ofcrc_req_gate #(
    .N (NUM_CLK)
  ) u_gate (
    .ref_clk_i (ref_clk_i),
    .rst_b_i   (rst_b_i),
    .enable_i  (req_en_q),
    .request_i (clk_request_i),
    .request_o (clk_request_o)
  );

  // Fault condition: lost clock or startup not yet stable
  assign cond_one = osc_one_lost_i | cnt_one_fault;
  assign cond_two = HAS_OSC_TWO & (osc_two_lost_i | cnt_two_fault);

  // One access per request; ack drops the cycle after it was given
  assign req_phase   = wb_cyc_i & wb_stb_i & ~ack_q & ~err_q;
  // Write lands at the edge where the master samples ack
  assign wr_low_byte = wb_cyc_i & wb_stb_i & ack_q & wb_we_i & wb_sel_i[0];
  assign wr_fault    = wr_low_byte & addr_hit(wb_adr_i, FAULT_OFFS);
  assign wr_reqen    = wr_low_byte & addr_hit(wb_adr_i, REQEN_OFFS);

  always_comb
  begin
    fault_view = '0;
    fault_view[OSC_ONE_CNTEN_BIT] = osc_one_start_counter_enable_q;
    fault_view[OSC_TWO_CNTEN_BIT] = osc_two_start_counter_enable_q;
    fault_view[OSC_ONE_FLAG_BIT]  = osc_one_fault_flag_q;
    fault_view[OSC_TWO_FLAG_BIT]  = osc_two_fault_flag_q;
    reqen_view = '0;
    reqen_view[NUM_CLK-1:0] = req_en_q;
    status_view = '0;
    status_view[STAT_COMB_BIT]  = comb_flag_q;
    status_view[STAT_COND1_BIT] = cond_one;
    status_view[STAT_COND2_BIT] = cond_two;
    status_view[STAT_CLK_LSB +: NUM_CLK] = clk_request_o;
  end

  always_comb
  begin
    osc_one_start_counter_enable_d = osc_one_start_counter_enable_q;
    osc_two_start_counter_enable_d = osc_two_start_counter_enable_q;
    osc_one_fault_flag_d           = osc_one_fault_flag_q;
    osc_two_fault_flag_d           = osc_two_fault_flag_q;
    req_en_d                       = req_en_q;
    if (wr_fault)
    begin
      osc_one_start_counter_enable_d = wb_dat_i[OSC_ONE_CNTEN_BIT];
      osc_two_start_counter_enable_d = wb_dat_i[OSC_TWO_CNTEN_BIT];
      osc_one_fault_flag_d = wb_dat_i[OSC_ONE_FLAG_BIT];
      osc_two_fault_flag_d = wb_dat_i[OSC_TWO_FLAG_BIT];
    end
    if (wr_reqen)
    begin
      req_en_d = wb_dat_i[NUM_CLK-1:0];
    end
    if (cond_one)
    begin
      osc_one_fault_flag_d = 1'b1;
    end
    if (cond_two)
    begin
      osc_two_fault_flag_d = 1'b1;
    end
    if (!HAS_OSC_TWO)
    begin
      osc_two_fault_flag_d = 1'b0;
    end
  end

  // Set again while any flag set
  assign comb_flag_d = osc_one_fault_flag_d | osc_two_fault_flag_d;

  always_comb
  begin
    ack_d   = 1'b0;
    err_d   = 1'b0;
    rdata_d = '0;
    if (req_phase)
    begin
      unique case (1'b1)
        addr_hit(wb_adr_i, FAULT_OFFS):
        begin
          ack_d   = 1'b1;
          rdata_d = {16'h0000, fault_view};
        end
        addr_hit(wb_adr_i, REQEN_OFFS):
        begin
          ack_d   = 1'b1;
          rdata_d = {16'h0000, reqen_view};
        end
        addr_hit(wb_adr_i, STATUS_OFFS):
        begin
          ack_d   = 1'b1;
          rdata_d = {16'h0000, status_view};
        end
        default:
        begin
          err_d = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
    begin
      osc_two_start_counter_enable_q <= FAULT_RESET[OSC_TWO_CNTEN_BIT];
      osc_one_start_counter_enable_q <= FAULT_RESET[OSC_ONE_CNTEN_BIT];
      osc_one_fault_flag_q           <= FAULT_RESET[OSC_ONE_FLAG_BIT];
      osc_two_fault_flag_q           <= FAULT_RESET[OSC_TWO_FLAG_BIT];
      // Sub-main, main, aux reset to one
      req_en_q                       <= REQEN_RESET[NUM_CLK-1:0];
      comb_flag_q                    <= FAULT_RESET[OSC_ONE_FLAG_BIT];
      ack_q                          <= 1'b0;
      err_q                          <= 1'b0;
      rdata_q                        <= '0;
    end
    else
    begin
      osc_two_start_counter_enable_q <= osc_two_start_counter_enable_d;
      osc_one_start_counter_enable_q <= osc_one_start_counter_enable_d;
      osc_one_fault_flag_q           <= osc_one_fault_flag_d;
      osc_two_fault_flag_q           <= osc_two_fault_flag_d;
      req_en_q                       <= req_en_d;
      comb_flag_q                    <= comb_flag_d;
      ack_q                          <= ack_d;
      err_q                          <= err_d;
      rdata_q                        <= rdata_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_err_o = err_q;
  assign wb_dat_o = rdata_q;
  assign combined_osc_fault_irq_flag_o = comb_flag_q;

  // Multi-step bus behaviour, built from named steps
  sequence s_flag_clear_write;
    wr_fault && !wb_dat_i[OSC_ONE_FLAG_BIT];
  endsequence

  sequence s_bus_taken;
    req_phase;
  endsequence

  sequence s_bus_answer;
    wb_ack_o != wb_err_o;
  endsequence

  sequence s_unmapped_taken;
    req_phase && !addr_hit(wb_adr_i, FAULT_OFFS) && !addr_hit(wb_adr_i, REQEN_OFFS)
      && !addr_hit(wb_adr_i, STATUS_OFFS);
  endsequence

  sequence s_write_masked;
    wb_cyc_i && wb_stb_i && wb_we_i && ack_q && !wb_sel_i[0];
  endsequence

  // First flag: sticky, set by fault, cleared by software
  a_flag_one_sticky: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    osc_one_fault_flag_q && !wr_fault |=> osc_one_fault_flag_q)
    else $error("first flag dropped without clear");
  a_flag_one_set: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    cond_one |=> osc_one_fault_flag_q)
    else $error("first flag not set by fault");
  a_flag_one_clear: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    s_flag_clear_write ##0 !cond_one |=> !osc_one_fault_flag_q)
    else $error("first flag not cleared");
  // Second flag likewise, or zero when absent
  a_flag_two_sticky: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    osc_two_fault_flag_q && !wr_fault |=> osc_two_fault_flag_q)
    else $error("second flag dropped without clear");
  a_flag_two_set: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    cond_two |=> osc_two_fault_flag_q)
    else $error("second flag not set by fault");
  a_flag_two_clear: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    wr_fault && !wb_dat_i[OSC_TWO_FLAG_BIT] && !cond_two |=> !osc_two_fault_flag_q)
    else $error("second flag not cleared");
  a_flag_two_absent: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    !HAS_OSC_TWO |-> !osc_two_fault_flag_q)
    else $error("absent oscillator flag set");
  // Combined flag and its output pin
  a_comb_follows: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    comb_flag_q == (osc_one_fault_flag_q | osc_two_fault_flag_q))
    else $error("combined flag mismatch");
  a_comb_out: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    osc_one_fault_flag_q || osc_two_fault_flag_q |-> combined_osc_fault_irq_flag_o)
    else $error("combined output low while a flag is set");
  // Counter enables and request gating
  a_cnten_write: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    wr_fault |=> osc_one_start_counter_enable_q == $past(wb_dat_i[OSC_ONE_CNTEN_BIT])
      && osc_two_start_counter_enable_q == $past(wb_dat_i[OSC_TWO_CNTEN_BIT]))
    else $error("counter enable write lost");
  a_cnt_off_quiet: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    !osc_one_start_counter_enable_q |-> !cnt_one_fault)
    else $error("disabled counter reports a fault");
  a_reqen_write: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    wr_reqen |=> req_en_q == $past(wb_dat_i[NUM_CLK-1:0]))
    else $error("request enable write lost");
  a_gate_pass: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    clk_request_o == $past(clk_request_i & req_en_q))
    else $error("gated request mismatch");
  a_masked_write: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    s_write_masked |=> $stable(req_en_q) && $stable(osc_one_start_counter_enable_q))
    else $error("write with low byte unselected took effect");
  // Reset values, seen right after a reset edge
  a_reset_reqen: assert property (@(posedge ref_clk_i)
    !rst_b_i |=> req_en_q == REQEN_RESET[NUM_CLK-1:0])
    else $error("request enable reset value wrong");
  a_reset_cnten: assert property (@(posedge ref_clk_i)
    !rst_b_i |=> osc_one_start_counter_enable_q && osc_two_start_counter_enable_q)
    else $error("counter enable reset value wrong");
  a_reset_flags: assert property (@(posedge ref_clk_i)
    !rst_b_i |=> osc_one_fault_flag_q && !osc_two_fault_flag_q)
    else $error("fault flag reset value wrong");
  // Bus answers
  a_reserved_zero: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (fault_view & ~FAULT_RW_MASK) == '0 && (reqen_view & ~REQEN_RW_MASK) == '0)
    else $error("reserved bit nonzero");
  a_upper_zero: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    wb_ack_o |-> wb_dat_o[31:REG_W] == '0)
    else $error("upper read half nonzero");
  a_rdata_idle: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    !wb_ack_o |-> wb_dat_o == '0)
    else $error("read data shown without ack");
  a_bus_answer: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    s_bus_taken |=> s_bus_answer)
    else $error("taken request not answered next cycle");
  a_err_unmapped: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    s_unmapped_taken |=> wb_err_o)
    else $error("unmapped address not refused");
  a_ack_single: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");
endmodule

// >>> bench/ofcrc_periph_model.sv
// Behavioural oscillators and peripheral requesters facing the clock block
`timescale 1ns/100ps
module ofcrc_periph_model
(
  input  wire logic       ref_clk_i,
  input  wire logic       rst_b_i,
  input  wire logic [1:0] run_i,
  input  wire logic [1:0] lost_i,
  input  wire logic [3:0] req_i,
  output logic      [1:0] tick_o,
  output logic      [1:0] lost_o,
  output logic      [3:0] req_o
);
  logic       phase_q;
  logic       phase_d;
  logic [1:0] tick_d;
  // Half system rate, so ticks never come back to back
  always_comb
  begin
    phase_d = ~phase_q;
    tick_d  = run_i & {2{phase_q}};
  end
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
    begin
      phase_q <= 1'h0;
      tick_o  <= 2'h0;
      lost_o  <= 2'h0;
      req_o   <= 4'h0;
    end
    else
    begin
      phase_q <= phase_d;
      tick_o  <= tick_d;
      lost_o  <= lost_i;
      req_o   <= req_i;
    end
  end
endmodule

// >>> bench/test_ofcrc_top.sv
// Register, fault flag and request gating tests for the clock fault block
`timescale 1ns/100ps
module test_ofcrc_top;
  import ofcrc_pkg::*;
  logic              clk = 1'h0;
  logic              rst_b = 1'h0;
  logic              cyc = 1'h0;
  logic              stb = 1'h0;
  logic              we = 1'h0;
  logic [ADDR_W-1:0] adr = 4'h0;
  logic [31:0]       wdat = 32'h0000_0000;
  logic [3:0]        sel = 4'hf;
  logic [31:0]       rdat;
  logic [31:0]       rdat2;
  logic              ack;
  logic              err;
  logic [1:0]        run = 2'h3;
  logic [1:0]        lost = 2'h0;
  logic [3:0]        req = 4'h0;
  logic [1:0]        tick;
  logic [1:0]        lost_w;
  logic [3:0]        req_w;
  logic [3:0]        req_o;
  logic              comb;
  logic [31:0]       dut2_rd;
  int                bad_count = 0;
  int                check_count = 0;

  initial
  begin
    forever #2.5 clk = ~clk;
  end

  ofcrc_periph_model i_periph (.ref_clk_i(clk), .rst_b_i(rst_b), .run_i(run),
    .lost_i(lost), .req_i(req), .tick_o(tick), .lost_o(lost_w), .req_o(req_w));

  ofcrc_top #(.HAS_OSC_TWO(1'b1), .RUN_CYCLES(8)) i_dut (.ref_clk_i(clk),
    .rst_b_i(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .wb_err_o(err), .osc_one_tick_i(tick[0]), .osc_one_lost_i(lost_w[0]),
    .osc_two_tick_i(tick[1]), .osc_two_lost_i(lost_w[1]), .clk_request_i(req_w),
    .clk_request_o(req_o), .combined_osc_fault_irq_flag_o(comb));

  // Build without the second oscillator, fed the same bus traffic
  ofcrc_top #(.HAS_OSC_TWO(1'b0), .RUN_CYCLES(8)) i_dut_no_two (.ref_clk_i(clk),
    .rst_b_i(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat2), .wb_ack_o(),
    .wb_err_o(), .osc_one_tick_i(tick[0]), .osc_one_lost_i(lost_w[0]),
    .osc_two_tick_i(tick[1]), .osc_two_lost_i(lost_w[1]), .clk_request_i(req_w),
    .clk_request_o(), .combined_osc_fault_irq_flag_o());

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Classic single cycle; ack is sampled before this edge's updates land
  task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    cyc  <= 1'h1;
    stb  <= 1'h1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    do
      @(posedge clk);
    while (!(ack === 1'h1 || err === 1'h1));
    q       = rdat;
    dut2_rd = rdat2;
    e       = err;
    cyc    <= 1'h0;
    stb    <= 1'h0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    bus(1'h1, a, d, q, e);
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] exp, input string n);
    logic [31:0] q;
    logic        e;
    bus(1'h0, a, 32'h0000_0000, q, e);
    chk(n, exp, q);
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    bad_count++;
    close_out();
  end

  initial
  begin : main_seq
    logic [31:0] q;
    logic        e;
    logic [31:0] exp;
    repeat (5) @(posedge clk);
    rst_b <= 1'h1;
    @(posedge clk);
    rd(REQEN_OFFS, 32'h0000_0007, "reqen_reset");
    rd(FAULT_OFFS, 32'h0000_00c3, "fault_start");
    chk("fault_start_no_two", 32'h0000_00c1, dut2_rd);
    repeat (40) @(posedge clk);
    wr(FAULT_OFFS, 32'hffff_ffc0);
    rd(FAULT_OFFS, 32'h0000_00c0, "fault_clear");
    chk("comb_clear", 32'h0000_0000, {31'h0000_0000, comb});
    wr(FAULT_OFFS, 32'hffff_ffff);
    rd(FAULT_OFFS, 32'h0000_00c3, "fault_ones");
    chk("comb_set", 32'h0000_0001, {31'h0000_0000, comb});
    for (int k = 0; k < 2; k++)
    begin
      exp = 32'h0000_00c0 | (32'h0000_0001 << k);
      wr(FAULT_OFFS, 32'h0000_00c0);
      lost[k] <= 1'h1;
      repeat (4) @(posedge clk);
      wr(FAULT_OFFS, 32'h0000_00c0);
      rd(FAULT_OFFS, exp, "fault_lost");
      chk("fault_lost_no_two", 32'h0000_00c0 | (k == 0), dut2_rd);
      chk("comb_lost", 32'h0000_0001, {31'h0000_0000, comb});
      lost[k] <= 1'h0;
      repeat (40) @(posedge clk);
      rd(FAULT_OFFS, exp, "fault_sticky");
      wr(FAULT_OFFS, 32'h0000_00c0);
    end
    run <= 2'h0;
    wr(FAULT_OFFS, 32'h0000_0000);
    repeat (40) @(posedge clk);
    rd(FAULT_OFFS, 32'h0000_0000, "counter_off");
    wr(FAULT_OFFS, 32'h0000_00c0);
    rd(FAULT_OFFS, 32'h0000_00c3, "counter_stalled");
    run <= 2'h3;
    repeat (40) @(posedge clk);
    wr(FAULT_OFFS, 32'h0000_00c0);
    rd(FAULT_OFFS, 32'h0000_00c0, "counter_settled");
    for (int i = 0; i < 16; i++)
    begin
      wr(REQEN_OFFS, 32'hffff_fff0 | i);
      rd(REQEN_OFFS, 32'(i), "reqen_rw");
      req <= 4'hf;
      repeat (3) @(posedge clk);
      chk("req_all", 32'(i), {28'h000_0000, req_o});
      req <= 4'h5;
      repeat (3) @(posedge clk);
      chk("req_some", 32'(i & 5), {28'h000_0000, req_o});
    end
    // Status view: gated requests, then live fault conditions
    rd(STATUS_OFFS, 32'h0000_0050, "status_gated");
    wr(STATUS_OFFS, 32'hffff_ffff);
    rd(STATUS_OFFS, 32'h0000_0050, "status_ro");
    lost <= 2'h3;
    repeat (4) @(posedge clk);
    rd(STATUS_OFFS, 32'h0000_0057, "status_lost");
    chk("status_lost_no_two", 32'h0000_0053, dut2_rd);
    lost <= 2'h0;
    // Low byte unselected: the write must not land
    sel <= 4'he;
    wr(REQEN_OFFS, 32'h0000_0000);
    sel <= 4'hf;
    rd(REQEN_OFFS, 32'h0000_000f, "reqen_sel_low");
    // Second reset in mid-run restores the register defaults
    rst_b <= 1'h0;
    repeat (5) @(posedge clk);
    rst_b <= 1'h1;
    @(posedge clk);
    rd(REQEN_OFFS, 32'h0000_0007, "reqen_rereset");
    rd(FAULT_OFFS, 32'h0000_00c3, "fault_rereset");
    bus(1'h0, 4'hc, 32'h0000_0000, q, e);
    chk("unmapped_err", 32'h0000_0001, {31'h0000_0000, e});
    close_out();
  end
endmodule
